// ### flash_selfprog_protected_ctrl.sv
// Protected flash mode control, unlock tracker, error flag and boot cluster swap
// What this block does
// - Mode register: inhibit, pin level, mode select
// - Reset loads 08H user, 0CH on-board
// - Bit 2 read-only, follows programming pin
// - Write/erase only when inhibit 0, pin 1
// - Select 00 normal, 01 self-programming
// - On-board mode ignores mode select bits
// - Flash address from CPU or firmware
// - Four-store unlock; only last store lands
// - Software re-keys before every mode change
// - Command register write-only, no stored content
// - Violation keeps register, sets error flag
// - Error flag sticky until zero written
// - Command write without key sets error
// - Other register during sequence sets error
// - Third store not inverse sets error
// - Fourth store mismatch sets error
// - Status register, bits 7-1 zero, reset 00H
// - Boot swap exchanges clusters 0000H, 1000H
// - Software holds inhibit low during writes
// - Software changes select only from RAM
//
// Our own choice: the AXI4-Lite interface to the registers.
module flash_selfprog_protected_ctrl
  import flash_ctrl_pkg::*;
(
  input  wire logic        CLK_IN,          // System clock
  input  wire logic        RST_B_IN,        // Synchronous reset, active low
  flash_ctrl_if.dev        BUS,             // Peripheral store and load path
  input  wire logic        PROG_PIN_IN,     // Programming mode pin level
  input  wire logic        BOOT_SWAP_IN,    // Boot swap active
  input  wire logic [15:0] CPU_ADDR_IN,     // CPU flash address
  input  wire logic [15:0] FW_ADDR_IN,      // Firmware flash address
  output logic             FLASH_WE_OUT,    // Write/erase permitted
  output logic             SELFPROG_OUT,    // Self-programming mode active
  output logic [15:0]      FLASH_ADDR_OUT,  // Address presented to flash
  output logic             SEQ_ERROR_OUT    // Protection error flag
);
  typedef struct packed {
    logic          inhibit;
    logic          pin_level;
    logic [1:0]    sel;
    logic          onboard;
    seq_state_type seq;
    logic [7:0]    target;
    logic          seq_error;
    logic [7:0]    load_data;
    logic          load_done;
    logic          flash_we;
    logic          selfprog;
    logic [15:0]   flash_addr;
  } ctrl_state_type;

  ctrl_state_type st;
  ctrl_state_type next_st;

  function automatic logic [7:0] mode_value(input ctrl_state_type s);
    logic [7:0] v;
    v = 8'h00;
    v[INHIBIT_BIT] = s.inhibit;
    v[PIN_BIT] = s.pin_level;
    v[SEL_HI_BIT] = s.sel[1];
    v[SEL_LO_BIT] = s.sel[0];
    return v;
  endfunction

  // Only inhibit and select are writable; the pin level bit always follows the pin
  function automatic ctrl_state_type load_mode(input ctrl_state_type s, input logic [7:0] v);
    ctrl_state_type r;
    r = s;
    r.inhibit = v[INHIBIT_BIT];
    r.sel = {v[SEL_HI_BIT], v[SEL_LO_BIT]};
    return r;
  endfunction

  function automatic logic [7:0] status_value(input ctrl_state_type s);
    logic [7:0] v;
    v = 8'h00;
    v[ERROR_BIT] = s.seq_error;
    return v;
  endfunction

  function automatic logic [15:0] swap_cluster(input logic [15:0] a, input logic swap);
    logic [15:0] r;
    r = a;
    if (swap && a < SWAP_AREA_END) begin
      r[CLUSTER_BIT] = ~a[CLUSTER_BIT];
    end
    return r;
  endfunction

  function automatic ctrl_state_type reset_state(input logic pin);
    ctrl_state_type r;
    logic [7:0]     v;
    r = '0;
    v = pin ? MODE_RESET_BOARD : MODE_RESET_USER;
    r = load_mode(r, v);
    r.pin_level = v[PIN_BIT];
    // On-board mode is latched from the pin while reset is held
    r.onboard = pin;
    r.seq = SEQ_IDLE;
    r.seq_error = STATUS_RESET[ERROR_BIT];
    return r;
  endfunction

  always_comb begin
    logic       set_err;
    logic       clr_err;
    logic       is_cmd;
    logic       is_mode;
    logic [7:0] d;
    next_st = st;
    set_err = 1'b0;
    clr_err = 1'b0;
    d = BUS.store_data;
    is_cmd = BUS.store_addr == CMD_ADDR;
    is_mode = BUS.store_addr == MODE_ADDR;
    // Pin level is resampled every cycle, so software can never change it
    next_st.pin_level = PROG_PIN_IN;
    next_st.load_done = 1'b0;
    if (BUS.store_valid && BUS.store_periph) begin
      case (st.seq)
        SEQ_IDLE: begin
          if (is_cmd) begin
            if (d == UNLOCK_KEY) begin
              next_st.seq = SEQ_KEYED;
            end else begin
              set_err = 1'b1;
            end
          end else if (is_mode) begin
            set_err = 1'b1;
          end
        end
        SEQ_KEYED: begin
          if (is_mode) begin
            next_st.target = d;
            next_st.seq = SEQ_VALUE;
          end else begin
            set_err = 1'b1;
          end
        end
        SEQ_VALUE: begin
          if (is_mode && d == ~st.target) begin
            next_st.seq = SEQ_INVER;
          end else begin
            set_err = 1'b1;
          end
        end
        SEQ_INVER: begin
          if (is_mode && d == st.target) begin
            next_st = load_mode(next_st, d);
            next_st.seq = SEQ_IDLE;
          end else begin
            set_err = 1'b1;
          end
        end
        default: begin
          next_st.seq = SEQ_IDLE;
        end
      endcase
      if (set_err) begin
        next_st.seq = SEQ_IDLE;
      end
      if (BUS.store_addr == STATUS_ADDR && !d[ERROR_BIT]) begin
        clr_err = 1'b1;
      end
    end
    // A new violation in the clearing cycle wins so it is never lost
    if (set_err) begin
      next_st.seq_error = 1'b1;
    end else if (clr_err) begin
      next_st.seq_error = 1'b0;
    end
    if (BUS.load_valid) begin
      next_st.load_done = 1'b1;
      if (BUS.load_addr == MODE_ADDR) begin
        next_st.load_data = mode_value(st);
      end else if (BUS.load_addr == STATUS_ADDR) begin
        next_st.load_data = status_value(st);
      end else begin
        // The write-only command register reads zero like any unmapped address
        next_st.load_data = 8'h00;
      end
    end
    // Built from the next mode so enable and mode bits change on the same edge
    next_st.flash_we = !next_st.inhibit && next_st.pin_level;
    next_st.selfprog = !st.onboard && next_st.sel == SEL_SELFPROG;
    // Firmware address only outside on-board mode; the swap applies to either source
    if (!st.onboard && next_st.sel[1]) begin
      next_st.flash_addr = swap_cluster(FW_ADDR_IN, BOOT_SWAP_IN);
    end else begin
      next_st.flash_addr = swap_cluster(CPU_ADDR_IN, BOOT_SWAP_IN);
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      st <= reset_state(PROG_PIN_IN);
    end else begin
      st <= next_st;
    end
  end

  assign BUS.load_data = st.load_data;
  assign BUS.load_done = st.load_done;
  assign FLASH_WE_OUT = st.flash_we;
  assign SELFPROG_OUT = st.selfprog;
  assign FLASH_ADDR_OUT = st.flash_addr;
  assign SEQ_ERROR_OUT = st.seq_error;
endmodule

// ### flash_ctrl_pkg.sv
// Shared constants and types for the flash self-programming protection logic
package flash_ctrl_pkg;
  localparam logic [15:0] CMD_ADDR         = 16'hFFC0;
  localparam logic [15:0] STATUS_ADDR      = 16'hFFC2;
  localparam logic [15:0] MODE_ADDR        = 16'hFFC4;
  localparam logic [7:0]  UNLOCK_KEY       = 8'hA5;
  localparam logic [7:0]  MODE_RESET_USER  = 8'h08;
  localparam logic [7:0]  MODE_RESET_BOARD = 8'h0C;
  localparam logic [7:0]  STATUS_RESET     = 8'h00;
  localparam int          INHIBIT_BIT      = 3;
  localparam int          PIN_BIT          = 2;
  localparam int          SEL_HI_BIT       = 1;
  localparam int          SEL_LO_BIT       = 0;
  localparam int          ERROR_BIT        = 0;
  localparam logic [1:0]  SEL_NORMAL       = 2'h0;
  localparam logic [1:0]  SEL_SELFPROG     = 2'h1;
  localparam int          CLUSTER_BIT      = 12;
  localparam logic [15:0] SWAP_AREA_END    = 16'h2000;
  localparam logic [3:0]  HOST_TARGET_OFS  = 4'h0;
  localparam logic [3:0]  HOST_DATA_OFS    = 4'h4;
  localparam logic [3:0]  HOST_GO_OFS      = 4'h8;
  localparam logic [3:0]  HOST_STATUS_OFS  = 4'hC;
  localparam int          GO_STORE_BIT     = 0;
  localparam int          GO_LOAD_BIT      = 1;
  localparam int          GO_UNLOCK_BIT    = 2;
  localparam int          TGT_PERIPH_BIT   = 16;
  localparam logic [1:0]  AXI_OKAY         = 2'h0;

  typedef enum logic [3:0] {
    SEQ_IDLE  = 4'h1,
    SEQ_KEYED = 4'h2,
    SEQ_VALUE = 4'h4,
    SEQ_INVER = 4'h8
  } seq_state_type;

  typedef enum logic [3:0] {
    HOST_IDLE   = 4'h1,
    HOST_STORE  = 4'h2,
    HOST_LOAD   = 4'h4,
    HOST_UNLOCK = 4'h8
  } host_state_type;
endpackage

// ### flash_ctrl_if.sv
// Peripheral store and load path between the processor side and the protection logic
interface flash_ctrl_if;
  logic        store_valid;
  logic        store_periph;
  logic [15:0] store_addr;
  logic [7:0]  store_data;
  logic        load_valid;
  logic [15:0] load_addr;
  logic [7:0]  load_data;
  logic        load_done;
  modport dev (input store_valid, store_periph, store_addr, store_data, load_valid, load_addr,
               output load_data, load_done);
  modport cpu (output store_valid, store_periph, store_addr, store_data, load_valid, load_addr,
               input load_data, load_done);
endinterface

// ### flash_selfprog_cpu_end.sv
// Processor-side end: AXI4-Lite command registers driving peripheral stores and loads
module flash_selfprog_cpu_end
  import flash_ctrl_pkg::*;
(
  input  wire logic        CLK_IN,          // System clock
  input  wire logic        RST_B_IN,        // Synchronous reset, active low
  flash_ctrl_if.cpu        BUS,             // Peripheral store and load path
  input  wire logic [3:0]  AXI_AWADDR_IN,   // Write address
  input  wire logic        AXI_AWVALID_IN,  // Write address valid
  output logic             AXI_AWREADY_OUT, // Write address ready
  input  wire logic [31:0] AXI_WDATA_IN,    // Write data
  input  wire logic [3:0]  AXI_WSTRB_IN,    // Write strobes
  input  wire logic        AXI_WVALID_IN,   // Write data valid
  output logic             AXI_WREADY_OUT,  // Write data ready
  output logic [1:0]       AXI_BRESP_OUT,   // Write response
  output logic             AXI_BVALID_OUT,  // Write response valid
  input  wire logic        AXI_BREADY_IN,   // Write response ready
  input  wire logic [3:0]  AXI_ARADDR_IN,   // Read address
  input  wire logic        AXI_ARVALID_IN,  // Read address valid
  output logic             AXI_ARREADY_OUT, // Read address ready
  output logic [31:0]      AXI_RDATA_OUT,   // Read data
  output logic [1:0]       AXI_RRESP_OUT,   // Read response
  output logic             AXI_RVALID_OUT,  // Read data valid
  input  wire logic        AXI_RREADY_IN    // Read data ready
);
  typedef struct packed {
    logic           aw_held;
    logic [3:0]     aw_addr;
    logic           w_held;
    logic [31:0]    w_data;
    logic [3:0]     w_strb;
    logic           awready;
    logic           wready;
    logic           bvalid;
    logic           arready;
    logic           rvalid;
    logic [31:0]    rdata;
    logic [16:0]    target;
    logic [7:0]     data;
    logic [7:0]     loaded;
    host_state_type fsm;
    logic [1:0]     step;
    logic           store_valid;
    logic           store_periph;
    logic [15:0]    store_addr;
    logic [7:0]     store_data;
    logic           load_valid;
  } host_state_struct_type;

  host_state_struct_type st;
  host_state_struct_type next_st;

  always_comb begin
    logic [31:0] go;
    next_st = st;
    go = 32'h0000_0000;
    next_st.store_valid = 1'b0;
    next_st.load_valid = 1'b0;
    if (AXI_AWVALID_IN && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = AXI_AWADDR_IN;
    end
    if (AXI_WVALID_IN && st.wready) begin
      next_st.w_held = 1'b1;
      next_st.w_data = AXI_WDATA_IN;
      next_st.w_strb = AXI_WSTRB_IN;
    end
    if (st.bvalid && AXI_BREADY_IN) begin
      next_st.bvalid = 1'b0;
    end
    if (st.aw_held && st.w_held) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      if (st.aw_addr == HOST_TARGET_OFS) begin
        if (st.w_strb[0]) next_st.target[7:0] = st.w_data[7:0];
        if (st.w_strb[1]) next_st.target[15:8] = st.w_data[15:8];
        if (st.w_strb[2]) next_st.target[TGT_PERIPH_BIT] = st.w_data[TGT_PERIPH_BIT];
      end else if (st.aw_addr == HOST_DATA_OFS) begin
        if (st.w_strb[0]) next_st.data = st.w_data[7:0];
      end else if (st.aw_addr == HOST_GO_OFS) begin
        if (st.w_strb[0]) go = st.w_data;
      end
    end
    case (st.fsm)
      HOST_IDLE: begin
        if (go[GO_UNLOCK_BIT]) begin
          next_st.fsm = HOST_UNLOCK;
          next_st.step = 2'h0;
        end else if (go[GO_STORE_BIT]) begin
          next_st.fsm = HOST_STORE;
          next_st.store_valid = 1'b1;
          next_st.store_periph = st.target[TGT_PERIPH_BIT];
          next_st.store_addr = st.target[15:0];
          next_st.store_data = st.data;
        end else if (go[GO_LOAD_BIT]) begin
          next_st.fsm = HOST_LOAD;
          next_st.load_valid = 1'b1;
          next_st.store_addr = st.target[15:0];
        end
      end
      HOST_STORE: begin
        next_st.fsm = HOST_IDLE;
      end
      HOST_LOAD: begin
        if (BUS.load_done) begin
          next_st.loaded = BUS.load_data;
          next_st.fsm = HOST_IDLE;
        end
      end
      HOST_UNLOCK: begin
        // Key, value, inverse, value on consecutive cycles
        next_st.store_valid = 1'b1;
        next_st.store_periph = 1'b1;
        next_st.store_addr = st.step == 2'h0 ? CMD_ADDR : MODE_ADDR;
        if (st.step == 2'h0) begin
          next_st.store_data = UNLOCK_KEY;
        end else if (st.step == 2'h2) begin
          next_st.store_data = ~st.data;
        end else begin
          next_st.store_data = st.data;
        end
        next_st.step = st.step + 2'h1;
        if (st.step == 2'h3) begin
          next_st.fsm = HOST_STORE;
        end
      end
      default: begin
        next_st.fsm = HOST_IDLE;
      end
    endcase
    if (st.rvalid && AXI_RREADY_IN) begin
      next_st.rvalid = 1'b0;
    end
    if (AXI_ARVALID_IN && st.arready) begin
      next_st.rvalid = 1'b1;
      if (AXI_ARADDR_IN == HOST_TARGET_OFS) begin
        next_st.rdata = {15'h0000, st.target};
      end else if (AXI_ARADDR_IN == HOST_DATA_OFS) begin
        next_st.rdata = {24'h00_0000, st.data};
      end else if (AXI_ARADDR_IN == HOST_STATUS_OFS) begin
        next_st.rdata = {16'h0000, st.loaded, 7'h00, st.fsm != HOST_IDLE};
      end else begin
        next_st.rdata = 32'h0000_0000;
      end
    end
    next_st.awready = !next_st.aw_held && !next_st.bvalid;
    next_st.wready = !next_st.w_held && !next_st.bvalid;
    next_st.arready = !next_st.rvalid;
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      st <= '0;
      st.fsm <= HOST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign AXI_AWREADY_OUT = st.awready;
  assign AXI_WREADY_OUT = st.wready;
  assign AXI_BRESP_OUT = AXI_OKAY;
  assign AXI_BVALID_OUT = st.bvalid;
  assign AXI_ARREADY_OUT = st.arready;
  assign AXI_RDATA_OUT = st.rdata;
  assign AXI_RRESP_OUT = AXI_OKAY;
  assign AXI_RVALID_OUT = st.rvalid;
  assign BUS.store_valid = st.store_valid;
  assign BUS.store_periph = st.store_periph;
  assign BUS.store_addr = st.store_addr;
  assign BUS.store_data = st.store_data;
  assign BUS.load_valid = st.load_valid;
  assign BUS.load_addr = st.store_addr;
endmodule

// ### flash_ctrl_assertions.sv
// Checks on the peripheral store and load path and the protection error flag
module flash_ctrl_assertions
  import flash_ctrl_pkg::*;
(
  input wire logic        CLK_IN,        // Clock
  input wire logic        RST_B_IN,      // Reset, active low
  input wire logic        store_valid,   // Store strobe
  input wire logic        store_periph,  // Peripheral store
  input wire logic [15:0] store_addr,    // Store address
  input wire logic [7:0]  store_data,    // Store data
  input wire logic        load_valid,    // Load request
  input wire logic [15:0] load_addr,     // Load address
  input wire logic [7:0]  load_data,     // Load answer
  input wire logic        load_done,     // Load answer strobe
  input wire logic        SEQ_ERROR_OUT  // Error flag
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] st;
  logic [7:0] v;
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);
  sequence s_store;
    store_valid && store_periph;
  endsequence
  sequence s_cmd;
    s_store ##0 store_addr == CMD_ADDR;
  endsequence
  sequence s_mode;
    s_store ##0 store_addr == MODE_ADDR;
  endsequence
  // Own unlock progress: 0 idle, 1 keyed, 2 value seen, 3 inverse seen
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      st <= 2'd0;
    end else if (store_valid && store_periph) begin
      if (st == 2'd0) begin
        st <= (store_addr == CMD_ADDR && store_data == UNLOCK_KEY) ? 2'd1 : 2'd0;
      end else if (store_addr != MODE_ADDR || st == 2'd3) begin
        st <= 2'd0;
      end else if (st == 2'd1) begin
        st <= 2'd2;
        v <= store_data;
      end else begin
        st <= (store_data == ~v) ? 2'd3 : 2'd0;
      end
    end
  end
  mode_read_a: assert property (load_valid && load_addr == MODE_ADDR |=> load_done && load_data[7:4] == 4'h0)
    else $error("mode read upper bits set");
  status_read_a: assert property (load_valid && load_addr == STATUS_ADDR
    |=> load_done && load_data == {7'h00, $past(SEQ_ERROR_OUT)}) else $error("status read wrong");
  bad_key_a: assert property (s_cmd ##0 (st != 2'd0 || store_data != UNLOCK_KEY) |=> SEQ_ERROR_OUT)
    else $error("bad command store not flagged");
  wrong_target_a: assert property (s_store ##0 (st != 2'd0 && store_addr != MODE_ADDR) |=> SEQ_ERROR_OUT)
    else $error("foreign store in sequence not flagged");
  bad_inverse_a: assert property (s_mode ##0 (st == 2'd2 && store_data != ~v) |=> SEQ_ERROR_OUT)
    else $error("wrong inverse not flagged");
  bad_repeat_a: assert property (s_mode ##0 (st == 2'd3 && store_data != v) |=> SEQ_ERROR_OUT)
    else $error("wrong final value not flagged");
  direct_write_a: assert property (s_mode ##0 st == 2'd0 |=> SEQ_ERROR_OUT)
    else $error("unkeyed mode store not flagged");
  err_sticky_a: assert property (SEQ_ERROR_OUT && !(store_valid && store_periph && store_addr == STATUS_ADDR
    && !store_data[0]) |=> SEQ_ERROR_OUT) else $error("error flag dropped");
  clean_unlock_a: assert property (s_mode ##0 (st == 2'd3 && store_data == v && !SEQ_ERROR_OUT)
    |=> !SEQ_ERROR_OUT) else $error("good sequence flagged");
endmodule

// ### flash_selfprog_protected_ctrl_test.sv
// Self-checking bench: AXI-driven processor end facing the protection logic
module flash_selfprog_protected_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  import flash_ctrl_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        prog_pin = 1'b0;
  logic        boot_swap = 1'b0;
  logic [15:0] cpu_addr = 16'h0000;
  logic [15:0] fw_addr = 16'h0000;
  logic [3:0]  awaddr = 4'h0;
  logic [3:0]  araddr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        arvalid = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, flash_we, selfprog, seq_error;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] flash_addr;
  int          error_cnt = 0;
  int          checks_done = 0;
  // Store low address byte and data, first store in the top byte; a zero address ends the row
  localparam logic [31:0] VA [6] = '{32'hC000_0000, 32'hC0C2_0000, 32'hC0C4_C400, 32'hC0C4_C4C4,
                                     32'hC400_0000, 32'hC0C4_C000};
  localparam logic [31:0] VD [6] = '{32'h5A00_0000, 32'hA500_0000, 32'hA501_0100, 32'hA501_FE00,
                                     32'h0100_0000, 32'hA501_A500};
  flash_ctrl_if link ();
  flash_selfprog_protected_ctrl i_flash_selfprog_protected_ctrl (.CLK_IN(clk), .RST_B_IN(rst_b), .BUS(link),
    .PROG_PIN_IN(prog_pin), .BOOT_SWAP_IN(boot_swap), .CPU_ADDR_IN(cpu_addr), .FW_ADDR_IN(fw_addr),
    .FLASH_WE_OUT(flash_we), .SELFPROG_OUT(selfprog), .FLASH_ADDR_OUT(flash_addr), .SEQ_ERROR_OUT(seq_error));
  flash_selfprog_cpu_end i_flash_selfprog_cpu_end (.CLK_IN(clk), .RST_B_IN(rst_b), .BUS(link),
    .AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awvalid), .AXI_AWREADY_OUT(awready), .AXI_WDATA_IN(wdata),
    .AXI_WSTRB_IN(4'hF), .AXI_WVALID_IN(wvalid), .AXI_WREADY_OUT(wready), .AXI_BRESP_OUT(bresp),
    .AXI_BVALID_OUT(bvalid), .AXI_BREADY_IN(1'b1), .AXI_ARADDR_IN(araddr), .AXI_ARVALID_IN(arvalid),
    .AXI_ARREADY_OUT(arready), .AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rvalid),
    .AXI_RREADY_IN(1'b1));
  flash_ctrl_assertions i_flash_ctrl_assertions (.CLK_IN(clk), .RST_B_IN(rst_b), .store_valid(link.store_valid),
    .store_periph(link.store_periph), .store_addr(link.store_addr), .store_data(link.store_data),
    .load_valid(link.load_valid), .load_addr(link.load_addr), .load_data(link.load_data),
    .load_done(link.load_done), .SEQ_ERROR_OUT(seq_error));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic do_reset;
    rst_b <= 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
  endtask
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    check("bresp", bresp, AXI_OKAY);
  endtask
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    check("rresp", rresp, AXI_OKAY);
  endtask
  task automatic dev_op(input int b, input logic p, input logic [15:0] a, input logic [7:0] d);
    logic [31:0] r;
    axi_write(HOST_TARGET_OFS, {15'h0000, p, a});
    axi_write(HOST_DATA_OFS, {24'h00_0000, d});
    axi_write(HOST_GO_OFS, 32'h0000_0001 << b);
    r = 32'h0000_0001;
    for (int n = 0; n < 20 && r[0] !== 1'b0; n++)
      axi_read(HOST_STATUS_OFS, r);
    check("busy", r[0], 1'b0);
  endtask
  task automatic load(input logic [15:0] a, output logic [7:0] d);
    logic [31:0] r;
    dev_op(GO_LOAD_BIT, 1'b1, a, 8'h00);
    axi_read(HOST_STATUS_OFS, r);
    d = r[15:8];
  endtask
  task automatic t_reset;
    logic [7:0] m;
    logic [31:0] r;
    load(MODE_ADDR, m);
    check("mode reset", m, 8'h08);
    load(STATUS_ADDR, m);
    check("status reset", m, 8'h00);
    load(CMD_ADDR, m);
    check("command read", m, 8'h00);
    check("write enable", flash_we, 1'b0);
    axi_read(HOST_GO_OFS, r);
    check("go read", r, 32'h0000_0000);
    axi_read(HOST_TARGET_OFS, r);
    check("target read", r, 32'h0001_FFC0);
  endtask
  task automatic t_modes;
    logic [7:0] m;
    for (int i = 0; i < 16; i++) begin
      prog_pin <= i[3];
      cpu_addr <= 16'h3456;
      fw_addr <= 16'h789A;
      dev_op(GO_UNLOCK_BIT, 1'b1, MODE_ADDR, {4'hA, i[2], ~i[3], i[1:0]});
      load(MODE_ADDR, m);
      check("mode", m, {4'h0, i[2], i[3], i[1:0]});
      check("write enable", flash_we, !i[2] && i[3]);
      check("selfprog", selfprog, i[1:0] == 2'h1);
      check("flash addr", flash_addr, i[1] ? 16'h789A : 16'h3456);
      check("error", seq_error, 1'b0);
    end
  endtask
  task automatic t_nonperiph;
    logic [7:0] m;
    dev_op(GO_STORE_BIT, 1'b1, CMD_ADDR, 8'hA5);
    dev_op(GO_STORE_BIT, 1'b0, CMD_ADDR, 8'h5A);
    dev_op(GO_STORE_BIT, 1'b1, MODE_ADDR, 8'h01);
    dev_op(GO_STORE_BIT, 1'b0, STATUS_ADDR, 8'h00);
    dev_op(GO_STORE_BIT, 1'b1, MODE_ADDR, 8'hFE);
    dev_op(GO_STORE_BIT, 1'b1, MODE_ADDR, 8'h01);
    load(MODE_ADDR, m);
    check("mode", m, 8'h05);
    check("error", seq_error, 1'b0);
  endtask
  task automatic t_violation;
    logic [7:0] m0;
    logic [7:0] m1;
    for (int c = 0; c < 6; c++) begin
      load(MODE_ADDR, m0);
      for (int k = 3; k >= 0 && VA[c][8*k +: 8] != 8'h00; k--)
        dev_op(GO_STORE_BIT, 1'b1, {8'hFF, VA[c][8*k +: 8]}, VD[c][8*k +: 8]);
      check("error set", seq_error, 1'b1);
      load(MODE_ADDR, m1);
      check("mode kept", m1, m0);
      dev_op(GO_UNLOCK_BIT, 1'b1, MODE_ADDR, 8'h08);
      check("sticky", seq_error, 1'b1);
      load(STATUS_ADDR, m1);
      check("status", m1, 8'h01);
      dev_op(GO_STORE_BIT, 1'b1, STATUS_ADDR, 8'hFE);
      check("cleared", seq_error, 1'b0);
    end
  endtask
  task automatic t_swap;
    logic [15:0] a;
    boot_swap <= 1'b1;
    for (int j = 0; j < 3; j++) begin
      a = (j == 0) ? 16'h0123 : (j == 1) ? 16'h1FFF : 16'h2345;
      cpu_addr <= a;
      fw_addr <= a;
      repeat (3) @(posedge clk);
      check("swap addr", flash_addr, (a < 16'h2000) ? a ^ 16'h1000 : a);
    end
    boot_swap <= 1'b0;
  endtask
  task automatic t_onboard;
    logic [7:0] m;
    prog_pin <= 1'b1;
    cpu_addr <= 16'h3456;
    fw_addr <= 16'h789A;
    do_reset;
    load(MODE_ADDR, m);
    check("onboard reset", m, 8'h0C);
    for (int s = 1; s < 3; s++) begin
      dev_op(GO_UNLOCK_BIT, 1'b1, MODE_ADDR, s[7:0]);
      check("selfprog", selfprog, 1'b0);
      check("flash addr", flash_addr, 16'h3456);
      check("write enable", flash_we, 1'b1);
    end
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    final_report;
  end
  initial begin
    do_reset;
    t_reset;
    t_modes;
    t_nonperiph;
    t_violation;
    t_swap;
    t_onboard;
    final_report;
  end
endmodule
